// ### misc_cfg_defs.svh
`ifndef MISC_CFG_DEFS_SVH
`define MISC_CFG_DEFS_SVH

// Command code of the configuration word
`define MISC_CFG_CODE        8'hd1
`define MISC_CFG_RESET       16'h0000

// Field positions
`define MIN_DUTY_HI          15
`define MIN_DUTY_LO          14
`define MIN_DUTY_EN_BIT      13
`define ALT_RAMP_DOWN_BIT    12
`define SYNC_TIMEOUT_BIT     11
`define FEED_FWD_BIT         9
`define FAULT_SPREAD_BIT     8
`define SYNC_INPUT_MODE_BIT  6
`define SYNC_OUT_CTRL_BIT    5
`define LOWSIDE_MODE_BIT     2
`define STANDBY_HI           1
`define STANDBY_LO           0

// Standby codes
`define STANDBY_LOW_POWER    2'h0
`define STANDBY_MONITOR      2'h1
`define STANDBY_RESERVED     2'h2
`define STANDBY_PULSED       2'h3

// Timing
`define CLK_FREQ_MHZ         40
`define SYNC_OFF_TIME_MS     500
`define SYNC_OFF_CYCLES      (`SYNC_OFF_TIME_MS * 1000 * `CLK_FREQ_MHZ)

`endif

// ### misc_cfg_pkg.sv
`default_nettype none

package misc_cfg_pkg;

  typedef enum logic [1:0] {
    T_IDLE,
    T_COUNT,
    T_EXPIRED
  } timer_state_t;

  typedef struct packed {
    timer_state_t state;
    logic [31:0]  count;
    logic         expired;
  } timer_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic        rsp_valid;
    logic        rsp_nack;
    logic [15:0] rsp_data;
    logic        cml_fault;
    logic [2:0]  min_duty;
    logic        out_hiz;
    logic        sync_oe;
    logic        ext_clk;
    logic        ff_correct;
    logic        lowside_on;
    logic        shutdown_now;
    logic        seq_shutdown;
    logic        low_power;
    logic        mon_cont;
    logic        mon_pulsed;
  } cfg_state_t;

endpackage

`default_nettype wire

// ### sync_timer_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sync_timer_if;
  logic arm;
  logic expired;
  modport ctrl  (output arm, input expired);
  modport timer (input arm, output expired);
endinterface

`default_nettype wire

// ### sync_off_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "misc_cfg_defs.svh"

// Counts the delay after disable before the switching clock output stops
module sync_off_timer #(
  parameter int unsigned OFF_CYCLES = `SYNC_OFF_CYCLES
) (
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  sync_timer_if.timer  tmr
);

  misc_cfg_pkg::timer_t t_q;
  misc_cfg_pkg::timer_t t_d;

  always_comb begin
    t_d = t_q;
    unique case (t_q.state)
      misc_cfg_pkg::T_IDLE: begin
        t_d.count = 32'h0000_0000;
        if (tmr.arm) begin
          t_d.state = misc_cfg_pkg::T_COUNT;
        end
      end
      misc_cfg_pkg::T_COUNT: begin
        if (!tmr.arm) begin
          t_d.state = misc_cfg_pkg::T_IDLE;
        end else if (t_q.count >= OFF_CYCLES - 32'h0000_0002) begin
          t_d.state = misc_cfg_pkg::T_EXPIRED;
        end else begin
          t_d.count = t_q.count + 32'h0000_0001;
        end
      end
      misc_cfg_pkg::T_EXPIRED: begin
        if (!tmr.arm) begin
          t_d.state = misc_cfg_pkg::T_IDLE;
        end
      end
      default: t_d.state = misc_cfg_pkg::T_IDLE;
    endcase
    t_d.expired = (t_d.state == misc_cfg_pkg::T_EXPIRED);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign tmr.expired = t_q.expired;

  a_timer_drops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tmr.arm |=> !tmr.expired)
    else $error("timer stays expired after disarm");

endmodule

`default_nettype wire

// ### misc_cfg_reg.sv
// Summary of operation
// - Two-bit code selects ramp minimum duty of one to four 256ths.
// - Minimum duty during ramps is enforced only when its enable bit is set.
// - Alternate ramp-down holds output high-impedance until undervoltage threshold.
// - With time-out set, clock output stops 500 ms after disable.
// - Feed-forward bit zero corrects loop coefficients for input voltage.
// - Spreading off and sequencing off: peer faults are ignored.
// - Spreading off and sequencing on: shut down in sequence from failure.
// - Spreading on: a peer fault in the group shuts down immediately.
// - Clock input mode selects strap-based or external clock switching.
// - Clock output bit drives switching clock out when internal oscillator used.
// - Low-side mode bit keeps low-side drive on while disabled.
// - Standby 00: disabled low power, telemetry reads raise communication fault.
// - Standby 01: monitor continuously while disabled, telemetry available.
// - Standby 11: pulsed monitoring, telemetry on read; 10 reserved.
`timescale 1ns/1ps
`default_nettype none
`include "misc_cfg_defs.svh"

module misc_cfg_reg #(
  parameter int unsigned SYNC_OFF_CYCLES = `SYNC_OFF_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic        cmd_write_i,
  input  wire logic [15:0] cmd_wdata_i,
  input  wire logic        cmd_telem_i,
  input  wire logic        enabled_i,
  input  wire logic        ramping_i,
  input  wire logic        ramp_down_i,
  input  wire logic        vout_above_uv_i,
  input  wire logic        peer_fault_i,
  input  wire logic        sequencing_en_i,
  output logic             rsp_valid_o,
  output logic             rsp_nack_o,
  output logic [15:0]      rsp_data_o,
  output logic             communication_fault_status_o,
  output logic [15:0]      cfg_o,
  output logic [2:0]       min_duty_o,
  output logic             out_hiz_o,
  output logic             sync_oe_o,
  output logic             sync_ext_clk_o,
  output logic             ff_correct_o,
  output logic             lowside_on_o,
  output logic             shutdown_now_o,
  output logic             seq_shutdown_o,
  output logic             low_power_o,
  output logic             monitor_cont_o,
  output logic             monitor_pulsed_o
);

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Minimum duty in 256ths of the period; zero means no limit
  function automatic logic [2:0] min_duty_parts(input logic [15:0] cfg);
    return {1'b0, cfg[`MIN_DUTY_HI:`MIN_DUTY_LO]} + 3'h1;
  endfunction

  function automatic logic [1:0] standby(input logic [15:0] cfg);
    return cfg[`STANDBY_HI:`STANDBY_LO];
  endfunction

  misc_cfg_pkg::cfg_state_t s_q;
  misc_cfg_pkg::cfg_state_t s_d;

  sync_timer_if tmr ();

  sync_off_timer #(.OFF_CYCLES(SYNC_OFF_CYCLES)) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .tmr     (tmr.timer)
  );

  assign tmr.arm = !enabled_i && s_q.cfg[`SYNC_TIMEOUT_BIT];

  always_comb begin
    logic [15:0] cfg;
    logic        lp;
    cfg = s_q.cfg;
    lp  = 1'b0;
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.rsp_nack  = 1'b0;
    s_d.cml_fault = 1'b0;
    lp = !enabled_i && (standby(s_q.cfg) == `STANDBY_LOW_POWER);
    if (cmd_valid_i) begin
      s_d.rsp_valid = 1'b1;
      if (cmd_code_i == `MISC_CFG_CODE) begin
        if (cmd_write_i) begin
          cfg = cmd_wdata_i;
          s_d.rsp_data = 16'h0000;
        end else begin
          s_d.rsp_data = s_q.cfg;
        end
      end else begin
        s_d.rsp_data = 16'h0000;
        s_d.rsp_nack = 1'b1;
        // Telemetry is refused only in low power; otherwise another block answers
        if (cmd_telem_i && lp) begin
          s_d.cml_fault = 1'b1;
        end else if (cmd_telem_i) begin
          s_d.rsp_nack = 1'b0;
        end
      end
    end
    s_d.cfg = cfg;
    s_d.min_duty = (ramping_i && s_q.cfg[`MIN_DUTY_EN_BIT]) ?
                   min_duty_parts(s_q.cfg) : 3'h0;
    s_d.out_hiz = ramp_down_i && s_q.cfg[`ALT_RAMP_DOWN_BIT] && vout_above_uv_i;
    s_d.ext_clk = s_q.cfg[`SYNC_INPUT_MODE_BIT];
    s_d.sync_oe = s_q.cfg[`SYNC_OUT_CTRL_BIT] && !s_q.cfg[`SYNC_INPUT_MODE_BIT]
                  && !tmr.expired;
    s_d.ff_correct = !s_q.cfg[`FEED_FWD_BIT];
    s_d.lowside_on = !enabled_i && s_q.cfg[`LOWSIDE_MODE_BIT];
    s_d.shutdown_now = peer_fault_i && s_q.cfg[`FAULT_SPREAD_BIT];
    s_d.seq_shutdown = peer_fault_i && !s_q.cfg[`FAULT_SPREAD_BIT]
                       && sequencing_en_i;
    s_d.low_power = lp;
    s_d.mon_cont = !enabled_i && (standby(s_q.cfg) == `STANDBY_MONITOR
                   || standby(s_q.cfg) == `STANDBY_RESERVED);
    s_d.mon_pulsed = !enabled_i && (standby(s_q.cfg) == `STANDBY_PULSED);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q     <= '0;
      s_q.cfg <= `MISC_CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid_o                  = s_q.rsp_valid;
  assign rsp_nack_o                   = s_q.rsp_nack;
  assign rsp_data_o                   = s_q.rsp_data;
  assign communication_fault_status_o = s_q.cml_fault;
  assign cfg_o                        = s_q.cfg;
  assign min_duty_o                   = s_q.min_duty;
  assign out_hiz_o                    = s_q.out_hiz;
  assign sync_oe_o                    = s_q.sync_oe;
  assign sync_ext_clk_o               = s_q.ext_clk;
  assign ff_correct_o                 = s_q.ff_correct;
  assign lowside_on_o                 = s_q.lowside_on;
  assign shutdown_now_o               = s_q.shutdown_now;
  assign seq_shutdown_o               = s_q.seq_shutdown;
  assign low_power_o                  = s_q.low_power;
  assign monitor_cont_o               = s_q.mon_cont;
  assign monitor_pulsed_o             = s_q.mon_pulsed;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_write;
    cmd_valid_i && cmd_write_i && cmd_code_i == `MISC_CFG_CODE;
  endsequence

  sequence s_cfg_read;
    cmd_valid_i && !cmd_write_i && cmd_code_i == `MISC_CFG_CODE;
  endsequence

  a_write_readback: assert property (s_cfg_write ##1 s_cfg_read |=>
    rsp_valid_o && rsp_data_o == $past(cmd_wdata_i, 2))
    else $error("written word not read back");
  a_min_duty_val: assert property (ramping_i && cfg_o[`MIN_DUTY_EN_BIT] |=>
    min_duty_o == {1'b0, $past(cfg_o[`MIN_DUTY_HI:`MIN_DUTY_LO])} + 3'h1)
    else $error("wrong minimum duty");
  a_min_duty_off: assert property (!cfg_o[`MIN_DUTY_EN_BIT] |=> min_duty_o == 3'h0)
    else $error("minimum duty applied while off");
  a_alt_ramp_hiz: assert property (out_hiz_o |-> $past(cfg_o[`ALT_RAMP_DOWN_BIT])
    && $past(vout_above_uv_i) && $past(ramp_down_i))
    else $error("high impedance without cause");
  // The state register leaves reset with the checks enabled, so its first loaded value shows one edge later
  a_feed_fwd: assert property ($past(rst_n) |->
    ff_correct_o == !$past(cfg_o[`FEED_FWD_BIT]))
    else $error("feed-forward mismatch");
  a_peer_ignore: assert property (!cfg_o[`FAULT_SPREAD_BIT] && !sequencing_en_i |=>
    !shutdown_now_o && !seq_shutdown_o)
    else $error("peer fault not ignored");
  a_seq_down: assert property (peer_fault_i && !cfg_o[`FAULT_SPREAD_BIT]
    && sequencing_en_i |=> seq_shutdown_o)
    else $error("sequenced shutdown missing");
  a_spread_stop: assert property (peer_fault_i && cfg_o[`FAULT_SPREAD_BIT]
    |=> shutdown_now_o)
    else $error("immediate shutdown missing");
  a_sync_out: assert property (sync_oe_o |-> $past(cfg_o[`SYNC_OUT_CTRL_BIT])
    && !$past(cfg_o[`SYNC_INPUT_MODE_BIT]))
    else $error("clock driven while not allowed");
  a_sync_always: assert property (!cfg_o[`SYNC_TIMEOUT_BIT] ##1 !cfg_o[`SYNC_TIMEOUT_BIT]
    && cfg_o[`SYNC_OUT_CTRL_BIT] && !cfg_o[`SYNC_INPUT_MODE_BIT] |=> sync_oe_o)
    else $error("clock stopped without time-out");
  a_lowside_drv: assert property (lowside_on_o == ($past(!enabled_i)
    && $past(cfg_o[`LOWSIDE_MODE_BIT])))
    else $error("low-side drive wrong");
  a_telem_fault: assert property (cmd_valid_i && cmd_telem_i && !enabled_i
    && cmd_code_i != `MISC_CFG_CODE && standby(cfg_o) == `STANDBY_LOW_POWER
    |=> communication_fault_status_o && rsp_nack_o)
    else $error("low-power telemetry read not faulted");
  a_telem_ok: assert property (cmd_valid_i && cmd_telem_i && cmd_code_i != `MISC_CFG_CODE
    && (enabled_i || standby(cfg_o) != `STANDBY_LOW_POWER)
    |=> !communication_fault_status_o && !rsp_nack_o)
    else $error("telemetry refused while available");
  a_pulsed_mon: assert property (!enabled_i && standby(cfg_o) == `STANDBY_PULSED
    |=> monitor_pulsed_o && !monitor_cont_o)
    else $error("pulsed monitor not selected");
  a_ext_clock: assert property (sync_ext_clk_o == $past(cfg_o[`SYNC_INPUT_MODE_BIT]))
    else $error("clock input mode mismatch");

endmodule

`default_nettype wire

// ### cmd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Management bus host: one word command per xfer call, a write then a read per wr_rd call, driven on falling edges
module cmd_host_model (
  input  wire logic        clk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic        rsp_nack_i,
  input  wire logic [15:0] rsp_data_i,
  input  wire logic        fault_i,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o,
  output logic             cmd_write_o,
  output logic [15:0]      cmd_wdata_o,
  output logic             cmd_telem_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_write_o = 1'b0;
    cmd_wdata_o = 16'h0000;
    cmd_telem_o = 1'b0;
  end

  task automatic xfer(input logic [7:0] code, input logic wr, input logic [15:0] wd,
                      input logic tel, output logic [15:0] rd, output logic [2:0] st);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o  = code;
    cmd_write_o = wr;
    cmd_wdata_o = wd;
    cmd_telem_o = tel;
    @(negedge clk_i);
    rd = rsp_data_i;
    st = {rsp_valid_i, rsp_nack_i, fault_i};
    cmd_valid_o = 1'b0;
    // Released lines carry the inverse so stale values never look valid
    cmd_code_o  = ~code;
    cmd_write_o = ~wr;
    cmd_wdata_o = ~wd;
    cmd_telem_o = ~tel;
  endtask

  // Write the word, then read it back in the very next cycle
  task automatic wr_rd(input logic [15:0] wd, output logic [15:0] rd);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o  = 8'hd1;
    cmd_write_o = 1'b1;
    cmd_wdata_o = wd;
    cmd_telem_o = 1'b0;
    @(negedge clk_i);
    cmd_write_o = 1'b0;
    @(negedge clk_i);
    rd = rsp_data_i;
    cmd_valid_o = 1'b0;
    cmd_code_o  = 8'h2e;
    cmd_write_o = 1'b1;
    cmd_wdata_o = ~wd;
    cmd_telem_o = 1'b1;
  endtask
endmodule

`default_nettype wire

// ### regulator_misc_config_register_tb.sv
`timescale 1ns/1ps
`default_nettype none

module regulator_misc_config_register_tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        enabled_i = 1'b0;
  logic        ramping_i = 1'b0;
  logic        ramp_down_i = 1'b0;
  logic        vout_above_uv_i = 1'b0;
  logic        peer_fault_i = 1'b0;
  logic        sequencing_en_i = 1'b0;
  wire logic   cmd_valid, cmd_write, cmd_telem;
  wire logic [7:0]  cmd_code;
  wire logic [15:0] cmd_wdata;
  logic        rsp_valid, rsp_nack, cml, out_hiz_o, sync_oe_o, sync_ext_clk_o, ff_correct_o;
  logic        lowside_on_o, shutdown_now_o, seq_shutdown_o, low_power_o;
  logic        monitor_cont_o, monitor_pulsed_o;
  logic [15:0] rsp_data, cfg_o, rd;
  logic [2:0]  min_duty_o, st;
  int          fails = 0;
  int          n_tests = 0;
  localparam logic [2:0] SB_EXP [4] = '{3'b100, 3'b010, 3'b010, 3'b001};

  always #12.5 clk_i = ~clk_i;

  cmd_host_model host (.clk_i(clk_i), .rsp_valid_i(rsp_valid), .rsp_nack_i(rsp_nack),
    .rsp_data_i(rsp_data), .fault_i(cml), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
    .cmd_write_o(cmd_write), .cmd_wdata_o(cmd_wdata), .cmd_telem_o(cmd_telem));

  misc_cfg_reg #(.SYNC_OFF_CYCLES(20)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_write_i(cmd_write),
    .cmd_wdata_i(cmd_wdata), .cmd_telem_i(cmd_telem), .enabled_i(enabled_i),
    .ramping_i(ramping_i), .ramp_down_i(ramp_down_i), .vout_above_uv_i(vout_above_uv_i),
    .peer_fault_i(peer_fault_i), .sequencing_en_i(sequencing_en_i),
    .rsp_valid_o(rsp_valid), .rsp_nack_o(rsp_nack), .rsp_data_o(rsp_data),
    .communication_fault_status_o(cml), .cfg_o(cfg_o), .min_duty_o(min_duty_o),
    .out_hiz_o(out_hiz_o), .sync_oe_o(sync_oe_o), .sync_ext_clk_o(sync_ext_clk_o),
    .ff_correct_o(ff_correct_o), .lowside_on_o(lowside_on_o),
    .shutdown_now_o(shutdown_now_o), .seq_shutdown_o(seq_shutdown_o),
    .low_power_o(low_power_o), .monitor_cont_o(monitor_cont_o),
    .monitor_pulsed_o(monitor_pulsed_o));

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write the word, then let derived outputs settle
  task automatic wr(input logic [15:0] w);
    host.xfer(8'hd1, 1'b1, w, 1'b0, rd, st);
    check({13'h0, st}, 16'h0004);
    check(cfg_o, w);
    @(negedge clk_i);
  endtask

  task automatic rd_chk(input logic [15:0] exp);
    host.xfer(8'hd1, 1'b0, 16'h0000, 1'b0, rd, st);
    check(rd, exp);
  endtask

  task automatic t_regs;
    check({13'h0, ff_correct_o, low_power_o, sync_oe_o}, 16'h0006);
    rd_chk(16'h0000);
    wr(16'hffff);
    rd_chk(16'hffff);
    wr(16'h0498);
    rd_chk(16'h0498);
    check({13'h0, min_duty_o}, 16'h0000);
    host.xfer(8'hd2, 1'b1, 16'h1234, 1'b0, rd, st);
    check({13'h0, st}, 16'h0006);
    rd_chk(16'h0498);
    host.wr_rd(16'h5a3c, rd);
    check(rd, 16'h5a3c);
  endtask

  task automatic t_ramp;
    enabled_i = 1'b1;
    ramping_i = 1'b1;
    ramp_down_i = 1'b1;
    vout_above_uv_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr({2'(i), 1'b1, 13'h0});
      check({13'h0, min_duty_o}, 16'(i + 1));
    end
    wr(16'hc000);
    check({13'h0, min_duty_o}, 16'h0000);
    wr(16'h1000);
    check({15'h0, out_hiz_o}, 16'h0001);
    vout_above_uv_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check({15'h0, out_hiz_o}, 16'h0000);
    wr(16'h0200);
    check({15'h0, ff_correct_o}, 16'h0000);
    wr(16'h0060);
    check({14'h0, sync_ext_clk_o, sync_oe_o}, 16'h0002);
    wr(16'h0020);
    check({14'h0, sync_ext_clk_o, sync_oe_o}, 16'h0001);
    ramping_i = 1'b0;
    ramp_down_i = 1'b0;
  endtask

  task automatic t_faults;
    peer_fault_i = 1'b1;
    wr(16'h0100);
    check({14'h0, shutdown_now_o, seq_shutdown_o}, 16'h0002);
    sequencing_en_i = 1'b1;
    wr(16'h0000);
    check({14'h0, shutdown_now_o, seq_shutdown_o}, 16'h0001);
    sequencing_en_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check({14'h0, shutdown_now_o, seq_shutdown_o}, 16'h0000);
    peer_fault_i = 1'b0;
  endtask

  task automatic t_standby;
    host.xfer(8'h8b, 1'b0, 16'h0000, 1'b1, rd, st);
    check({13'h0, st}, 16'h0004);
    wr(16'h0004);
    check({15'h0, lowside_on_o}, 16'h0000);
    enabled_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check({15'h0, lowside_on_o}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr({14'h0, 2'(i)});
      check({13'h0, low_power_o, monitor_cont_o, monitor_pulsed_o}, {13'h0, SB_EXP[i]});
      host.xfer(8'h8b, 1'b0, 16'h0000, 1'b1, rd, st);
      check({13'h0, st}, (i == 0) ? 16'h0007 : 16'h0004);
    end
  endtask

  task automatic t_sync_off;
    enabled_i = 1'b1;
    wr(16'h0820);
    enabled_i = 1'b0;
    repeat (10) @(negedge clk_i);
    check({15'h0, sync_oe_o}, 16'h0001);
    repeat (20) @(negedge clk_i);
    check({15'h0, sync_oe_o}, 16'h0000);
    wr(16'h0020);
    repeat (30) @(negedge clk_i);
    check({15'h0, sync_oe_o}, 16'h0001);
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_regs();
    t_ramp();
    t_faults();
    t_standby();
    t_sync_off();
    finish_test();
  end

  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule

`default_nettype wire
